/* File: core/regs_consts.svh */
// Offsets, field positions, reset values and CRC constants of the capability/CRC/address registers
// Summary of operation
// RQ1 - Capability bits 8:7 report family code 01 (current family), read only.
// RQ2 - Capability bits 6:4 report interface revision 000, read only.
// RQ3 - Capability bits 3:0 report interface kind 0010, FIFO over the serial bus.
// RQ4 - Enable register bit 0 turns checksum on when 1; resets to 0.
// RQ5 - Reserved bits 7:1 of enable and 14:7 of address register read zero.
// RQ6 - Enable writes are accepted once power-on initialization has completed.
// RQ7 - Enable writes are accepted in the Idle or Ready command state.
// RQ8 - Enable writes may be ignored in Reception, Execution or Completion state.
// RQ9 - 16-bit read-only checksum register, default zero, holds last command/response CRC.
// RQ10 - CRC: poly 0x1021, init 0, reflected in and out, final XOR 0.
// RQ11 - "123456789" gives 0x8921; read at 0x44 returns low byte first.
// RQ12 - "1122334455" gives 0xD367, read back as 0x67 then 0xD3.
// RQ13 - With checksum on, CRC covers every byte of each received command.
// RQ14 - With checksum on, CRC covers every byte of each transmitted response.
// RQ15 - Command CRC is updated after the last byte, before expect falls.
// RQ16 - Command CRC holds from the fall of expect until execute go.
// RQ17 - Response CRC is updated after last byte read, before response-available falls.
// RQ18 - Response CRC holds from response-available fall until command ready written.
// RQ19 - Address register bits 6:0 hold the bus address in use, default 0x2E.
// RQ20 - A newly written bus address takes effect from the next master access.
// RQ21 - Write-only bit 15 set keeps the address across reset; clear makes it volatile.
// RQ22 - Host resolves conflicts writing with persistence set, clear for one power cycle.
// RQ23 - Reserved write bits are ignored; checksum is frozen while calculation is off.
// RQ24 - Capability bits 28:27 report address-change method 11, standard register mechanism.
`ifndef REGS_CONSTS_SVH
`define REGS_CONSTS_SVH

`define CAP_OFFSET 8'h30
`define ADDR_OFFSET 8'h38
`define CRC_EN_OFFSET 8'h40
`define CRC_OFFSET 8'h44

`define FAMILY_MSB 8
`define FAMILY_LSB 7
`define FAMILY_VAL 2'h1
`define REV_MSB 6
`define REV_LSB 4
`define REV_VAL 3'h0
`define KIND_MSB 3
`define KIND_LSB 0
`define KIND_VAL 4'h2
`define METHOD_MSB 28
`define METHOD_LSB 27
`define METHOD_VAL 2'h3

`define CRC_ON_POS 0
`define CRC_ON_RESET 1'h0
`define CRC_POLY 16'h1021
`define CRC_INIT 16'h0000
`define CRC_XOROUT 16'h0000
`define CRC_RESET 16'h0000

`define ID_MSB 6
`define ID_RESET 7'h2e
`define KEEP_POS 15

`endif

/* File: core/regs_pkg.sv */
// Types shared by the capability, checksum and bus-address register logic
package regs_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_evt_t;

  typedef struct packed {
    logic expect_more;
    logic response_available;
    logic execute_go;
    logic command_ready_bit;
  } handshake_t;

  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_ready = 5'h02,
    st_reception = 5'h04,
    st_execution = 5'h08,
    st_completion = 5'h10
  } cmd_state_t;

endpackage

/* File: core/crc_byte_step.sv */
// One byte step of the reflected 16-bit CRC
`timescale 1ns/10ps
`include "regs_consts.svh"
module crc_byte_step (
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [15:0] crc_out
);

  function automatic logic [15:0] reflect16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  localparam logic [15:0] POLY_REFL = reflect16(`CRC_POLY);

  logic [15:0] stage [0:8];

  // Reflected input: the byte enters at the low end and shifts right
  assign stage[0] = crc_in ^ {8'h00, data_in}; // RQ10

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign stage[g + 1] = stage[g][0] ? ((stage[g] >> 1) ^ POLY_REFL) : (stage[g] >> 1); // RQ10
    end
  endgenerate

  assign crc_out = stage[8];

endmodule

/* File: core/i2c_iface_csum_addr_regs.sv */
// Capability, checksum enable, checksum and bus-address registers of the serial-bus interface
`timescale 1ns/10ps
`include "regs_consts.svh"
module i2c_iface_csum_addr_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire regs_pkg::reg_req_t reg_req,
  input wire logic txn_end,
  input wire logic init_done,
  input wire regs_pkg::cmd_state_t cmd_state,
  input wire regs_pkg::handshake_t hs,
  input wire regs_pkg::byte_evt_t cmd_byte,
  input wire regs_pkg::byte_evt_t rsp_byte,
  input wire logic [6:0] nv_id,
  input wire logic nv_id_valid,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic [6:0] target_id,
  output logic nv_store,
  output logic [6:0] nv_store_id,
  output logic crc_on
);
  import regs_pkg::*;

  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;
  logic rd_valid_q;
  logic crc_on_q;
  logic [15:0] crc_q;
  logic [15:0] crc_run_q;
  logic [15:0] crc_next;
  logic [7:0] step_byte;
  logic step_ok;
  logic cmd_hold_q;
  logic rsp_hold_q;
  logic expect_prev_q;
  logic avail_prev_q;
  logic [6:0] target_id_q;
  logic [6:0] pend_id_q;
  logic pend_q;
  logic loaded_q;
  logic nv_store_q;
  logic [6:0] nv_store_id_q;
  logic wr_en_reg;
  logic wr_addr_reg;
  logic en_write_ok;
  logic expect_fall;
  logic avail_fall;
  logic [31:0] cap_word;

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign target_id = target_id_q;
  assign nv_store = nv_store_q;
  assign nv_store_id = nv_store_id_q;
  assign crc_on = crc_on_q;

  // Capability word: only the identification and address-method fields are non-zero
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[`FAMILY_MSB:`FAMILY_LSB] = `FAMILY_VAL; // RQ1
    cap_word[`REV_MSB:`REV_LSB] = `REV_VAL; // RQ2
    cap_word[`KIND_MSB:`KIND_LSB] = `KIND_VAL; // RQ3
    cap_word[`METHOD_MSB:`METHOD_LSB] = `METHOD_VAL; // RQ24
  end

  // Register read path; unmapped offsets read as zero
  always_comb begin
    rd_data_d = 32'h0000_0000;
    unique case (reg_req.addr)
      `CAP_OFFSET: rd_data_d = cap_word;
      `CRC_EN_OFFSET: rd_data_d[`CRC_ON_POS] = crc_on_q; // RQ5
      `CRC_OFFSET: rd_data_d[15:0] = crc_q; // RQ9 RQ11 RQ12
      `ADDR_OFFSET: rd_data_d[`ID_MSB:0] = target_id_q; // RQ19 RQ5
      default: rd_data_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_q <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= reg_req.rd;
      if (reg_req.rd) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  assign wr_en_reg = reg_req.wr && (reg_req.addr == `CRC_EN_OFFSET);
  assign wr_addr_reg = reg_req.wr && (reg_req.addr == `ADDR_OFFSET);
  // A mid-command change of the enable would split a CRC, so those writes are dropped
  assign en_write_ok = init_done && (cmd_state == st_idle || cmd_state == st_ready); // RQ6 RQ7 RQ8

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_on_q <= `CRC_ON_RESET; // RQ4
    end else if (wr_en_reg && en_write_ok) begin
      crc_on_q <= reg_req.wdata[`CRC_ON_POS]; // RQ4 RQ23
    end
  end

  // Hold windows opened by the falling handshake flags
  assign expect_fall = expect_prev_q && !hs.expect_more;
  assign avail_fall = avail_prev_q && !hs.response_available;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      expect_prev_q <= 1'b0;
      avail_prev_q <= 1'b0;
    end else begin
      expect_prev_q <= hs.expect_more;
      avail_prev_q <= hs.response_available;
    end
  end

  // Set wins over clear so a fall that meets go or ready is not lost
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd_hold_q <= 1'b0;
    end else if (expect_fall) begin
      cmd_hold_q <= 1'b1; // RQ16
    end else if (hs.execute_go) begin
      cmd_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rsp_hold_q <= 1'b0;
    end else if (avail_fall) begin
      rsp_hold_q <= 1'b1; // RQ18
    end else if (hs.command_ready_bit) begin
      rsp_hold_q <= 1'b0;
    end
  end

  // Command and response bytes never overlap; command bytes take precedence
  always_comb begin
    step_byte = rsp_byte.data;
    step_ok = rsp_byte.valid && !rsp_hold_q; // RQ14 RQ17 RQ18
    if (cmd_byte.valid) begin
      step_byte = cmd_byte.data;
      step_ok = !cmd_hold_q; // RQ13 RQ15 RQ16
    end
  end

  crc_byte_step u_step (
    .crc_in(crc_run_q),
    .data_in(step_byte),
    .crc_out(crc_next)
  );

  // Running value restarts at go (response begins) and at ready (next command begins)
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_run_q <= `CRC_INIT;
    end else if (hs.execute_go || hs.command_ready_bit) begin
      crc_run_q <= `CRC_INIT; // RQ10
    end else if (crc_on_q && step_ok) begin
      crc_run_q <= crc_next; // RQ13 RQ14
    end
  end

  // Visible value moves only on an accepted byte, so it holds through a restart
  // Shown byte-swapped: the first byte read out is the running remainder's high byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_q <= `CRC_RESET; // RQ9
    end else if (crc_on_q && step_ok && !hs.execute_go && !hs.command_ready_bit) begin
      crc_q <= {crc_next[7:0], crc_next[15:8]} ^ `CRC_XOROUT; // RQ11 RQ15 RQ17 RQ23
    end
  end

  // Persistent copy lives in external storage; it is read back once after reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
      pend_id_q <= `ID_RESET;
    end else if (wr_addr_reg) begin
      pend_q <= 1'b1;
      pend_id_q <= reg_req.wdata[`ID_MSB:0]; // RQ23
    end else if (txn_end) begin
      pend_q <= 1'b0;
    end
  end

  // New address applies at the end of the access that wrote it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      target_id_q <= `ID_RESET; // RQ19
    end else if (!loaded_q) begin
      if (nv_id_valid) begin
        target_id_q <= nv_id; // RQ21
      end
    end else if (pend_q && txn_end && !wr_addr_reg) begin
      target_id_q <= pend_id_q; // RQ20
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nv_store_q <= 1'b0;
      nv_store_id_q <= `ID_RESET;
    end else begin
      nv_store_q <= wr_addr_reg && reg_req.wdata[`KEEP_POS]; // RQ21
      if (wr_addr_reg && reg_req.wdata[`KEEP_POS]) begin
        nv_store_id_q <= reg_req.wdata[`ID_MSB:0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_family_code_read: assert property ( // RQ1
    reg_req.rd && reg_req.addr == `CAP_OFFSET |=> rd_valid_q && rd_data_q[8:7] == 2'h1)
    else $error("family code field wrong");

  a_link_revision_read: assert property ( // RQ2
    reg_req.rd && reg_req.addr == `CAP_OFFSET |=> rd_data_q[6:4] == 3'h0)
    else $error("interface revision field wrong");

  a_link_kind_read: assert property ( // RQ3
    reg_req.rd && reg_req.addr == `CAP_OFFSET |=> rd_data_q[3:0] == 4'h2)
    else $error("interface kind field wrong");

  a_method_field_read: assert property ( // RQ24
    reg_req.rd && reg_req.addr == `CAP_OFFSET |=> rd_data_q[28:27] == 2'h3)
    else $error("address change method field wrong");

  a_enable_reserved_zero: assert property ( // RQ5
    reg_req.rd && reg_req.addr == `CRC_EN_OFFSET |=> rd_data_q[31:1] == 31'h0)
    else $error("enable register reserved bits not zero");

  a_enable_write_taken: assert property ( // RQ7
    wr_en_reg && init_done && (cmd_state == st_idle || cmd_state == st_ready)
    |=> crc_on_q == $past(reg_req.wdata[0]))
    else $error("enable write in idle or ready not taken");

  a_enable_write_dropped: assert property ( // RQ8
    wr_en_reg && (cmd_state == st_reception || cmd_state == st_execution)
    |=> $stable(crc_on_q))
    else $error("enable write taken while busy");

  a_cmd_crc_hold: assert property ( // RQ16
    cmd_hold_q && !hs.execute_go && !hs.command_ready_bit |=> $stable(crc_q))
    else $error("command checksum moved inside hold window");

  a_rsp_crc_hold: assert property ( // RQ18
    rsp_hold_q && !cmd_byte.valid |=> $stable(crc_q))
    else $error("response checksum moved inside hold window");

  a_crc_frozen_off: assert property ( // RQ23
    !crc_on_q |=> $stable(crc_q))
    else $error("checksum changed while disabled");

  a_cmd_crc_update: assert property ( // RQ15
    crc_on_q && cmd_byte.valid && !cmd_hold_q && !hs.execute_go && !hs.command_ready_bit
    |=> crc_run_q == $past(crc_next) && crc_q == {crc_run_q[7:0], crc_run_q[15:8]})
    else $error("command byte not folded into checksum");

  a_crc_read_back: assert property ( // RQ11
    reg_req.rd && reg_req.addr == `CRC_OFFSET |=> rd_data_q == {16'h0000, $past(crc_q)})
    else $error("checksum read data wrong");

  a_id_read_back: assert property ( // RQ19
    reg_req.rd && reg_req.addr == `ADDR_OFFSET
    |=> rd_data_q == {25'h0, $past(target_id_q)})
    else $error("address read data wrong");

  a_id_next_access: assert property ( // RQ20
    loaded_q && pend_q && txn_end && !wr_addr_reg |=> target_id_q == $past(pend_id_q) ##1 1'b1)
    else $error("new address not applied at end of access");

  a_keep_store_pulse: assert property ( // RQ21
    wr_addr_reg && reg_req.wdata[15]
    |=> nv_store_q && nv_store_id_q == $past(reg_req.wdata[6:0]) ##1 !nv_store_q || $past(wr_addr_reg))
    else $error("persistent store not requested");

  a_rsp_crc_update: assert property ( // RQ17
    crc_on_q && rsp_byte.valid && !cmd_byte.valid && !rsp_hold_q && !hs.execute_go
    && !hs.command_ready_bit |=> crc_q == {$past(crc_next[7:0]), $past(crc_next[15:8])})
    else $error("response byte not folded into checksum");

  a_crc_run_restart: assert property ( // RQ10
    hs.execute_go || hs.command_ready_bit |=> crc_run_q == 16'h0000)
    else $error("running checksum not restarted");

  a_volatile_no_store: assert property ( // RQ21
    wr_addr_reg && !reg_req.wdata[15] |=> !nv_store_q)
    else $error("volatile address write requested a store");

  a_id_hold_no_end: assert property ( // RQ20
    loaded_q && !txn_end |=> $stable(target_id_q))
    else $error("address changed without end of access");

endmodule

/* File: test/nv_store_model.sv */
// Persistent address store that the device writes and reads back after each reset
`timescale 1ns/10ps
module nv_store_model (
  input wire logic clk,
  input wire logic nv_store,
  input wire logic [6:0] nv_store_id,
  output logic [6:0] nv_id,
  output logic nv_id_valid
);
  // Holds its content across device resets, so it has no reset of its own
  initial begin
    nv_id = 7'h55;
    nv_id_valid = 1'b0;
  end

  always @(posedge clk) begin
    if (nv_store) begin
      nv_id <= nv_store_id;
      nv_id_valid <= 1'b1;
    end
  end
endmodule

/* File: test/i2c_iface_csum_addr_regs_tb.sv */
// Self-checking bench for the capability, checksum and bus-address registers
`timescale 1ns/10ps
module i2c_iface_csum_addr_regs_tb;
  import regs_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t req = '0;
  logic txn_end = 1'b0;
  logic init_done = 1'b0;
  cmd_state_t st = st_idle;
  handshake_t hs = '0;
  byte_evt_t cb = '0;
  byte_evt_t rb = '0;
  logic [6:0] nv_id;
  logic nv_id_valid;
  logic [31:0] rd_data;
  logic rd_valid;
  logic [6:0] target_id;
  logic nv_store;
  logic [6:0] nv_store_id;
  logic crc_on;
  logic [31:0] d;
  int miscompares = 0;
  int num_checks = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  i2c_iface_csum_addr_regs i_dut (.clk(clk), .reset_n(reset_n), .reg_req(req),
    .txn_end(txn_end), .init_done(init_done), .cmd_state(st), .hs(hs), .cmd_byte(cb),
    .rsp_byte(rb), .nv_id(nv_id), .nv_id_valid(nv_id_valid), .rd_data(rd_data),
    .rd_valid(rd_valid), .target_id(target_id), .nv_store(nv_store),
    .nv_store_id(nv_store_id), .crc_on(crc_on));

  nv_store_model i_nv (.clk(clk), .nv_store(nv_store), .nv_store_id(nv_store_id),
    .nv_id(nv_id), .nv_id_valid(nv_id_valid));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic do_reset;
    reset_n = 1'b0;
    tick(12);
    reset_n = 1'b1;
    tick(2);
  endtask

  // All bus tasks start and end at a falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    tick(1);
    req = '{1'b1, 1'b0, a, v};
    tick(1);
    req = '0;
  endtask

  task automatic rd(input logic [7:0] a);
    tick(1);
    req = '{1'b0, 1'b1, a, 32'h0};
    tick(1);
    d = rd_data;
    req = '0;
  endtask

  task automatic send(input string s, input logic rsp);
    for (int i = 0; i < s.len(); i++) begin
      if (rsp) begin
        rb = '{1'b1, s[i]};
      end else begin
        cb = '{1'b1, s[i]};
      end
      tick(1);
    end
    cb = '0;
    rb = '0;
  endtask

  task automatic end_access;
    txn_end = 1'b1;
    tick(1);
    txn_end = 1'b0;
  endtask

  task automatic t_reset_values;
    rd(8'h30);
    check(d, 32'h1800_0082);
    check({31'h0, rd_valid}, 32'h1);
    tick(1);
    check({31'h0, rd_valid}, 32'h0);
    rd(8'h40);
    check(d, 32'h0);
    rd(8'h44);
    check(d, 32'h0);
    rd(8'h38);
    check(d, 32'h2e);
  endtask

  task automatic t_enable;
    wr(8'h40, 32'h1);
    check({31'h0, crc_on}, 32'h0);
    init_done = 1'b1;
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    check(d, 32'h1);
    st = st_ready;
    wr(8'h40, 32'h0);
    check({31'h0, crc_on}, 32'h0);
    st = st_idle;
    wr(8'h40, 32'h1);
  endtask

  task automatic t_crc;
    st = st_reception;
    hs.expect_more = 1'b1;
    send("123456789", 1'b0);
    rd(8'h44);
    check(d, 32'h8921);
    wr(8'h40, 32'h0);
    check({31'h0, crc_on}, 32'h1);
    hs.expect_more = 1'b0;
    tick(2);
    send("7", 1'b0);
    rd(8'h44);
    check(d, 32'h8921);
    hs.execute_go = 1'b1;
    st = st_execution;
    tick(1);
    hs.execute_go = 1'b0;
    wr(8'h40, 32'h0);
    check({31'h0, crc_on}, 32'h1);
    st = st_completion;
    hs.response_available = 1'b1;
    send("1122334455", 1'b1);
    rd(8'h44);
    check(d, 32'hd367);
    hs.response_available = 1'b0;
    tick(2);
    send("5", 1'b1);
    rd(8'h44);
    check(d, 32'hd367);
    hs.command_ready_bit = 1'b1;
    tick(1);
    hs.command_ready_bit = 1'b0;
    st = st_idle;
    wr(8'h40, 32'h0);
    send("1", 1'b0);
    rd(8'h44);
    check(d, 32'hd367);
  endtask

  task automatic t_addr;
    wr(8'h38, 32'h0000_ffc5);
    check({24'h0, nv_store, nv_store_id}, 32'hc5);
    check({25'h0, target_id}, 32'h2e);
    end_access;
    check({25'h0, target_id}, 32'h45);
    rd(8'h38);
    check(d, 32'h45);
    do_reset;
    check({25'h0, target_id}, 32'h45);
    wr(8'h38, 32'h0000_0033);
    check({31'h0, nv_store}, 32'h0);
    end_access;
    check({25'h0, target_id}, 32'h33);
    do_reset;
    check({25'h0, target_id}, 32'h45);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    do_reset;
    t_reset_values;
    t_enable;
    t_crc;
    t_addr;
    tally_and_finish;
  end

  // The whole sequence needs about 115 cycles; a hang is cut off well beyond that
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
endmodule
